// ### hw/mbr_pkg.sv
// Shared constants for the multi-byte register read link: addressing, bit slots, SCL timing.
// Assumes a 25 MHz system clock on both ends of the link.
package mbr_pkg;
   // Device address value is arbitrary.
   localparam logic [6:0] MBR_DEV_ADDR = 7'h2a;
   localparam int MBR_NREG = 16;
   localparam logic MBR_RW_WRITE = 1'b0;
   localparam logic MBR_RW_READ = 1'b1;
   localparam logic MBR_ACK = 1'b0;
   localparam logic MBR_NACK = 1'b1;
   localparam logic [3:0] MBR_ACK_SLOT = 4'h8;
   localparam logic [7:0] MBR_PTR_RST = 8'h00;
   localparam logic [7:0] MBR_REG_RST = 8'h00;
   localparam int MBR_SYS_NS = 40;
   localparam int MBR_SCL_HALF_NS = 5000;
   // Least half period, so rounded up to whole system clocks.
   localparam int MBR_SCL_HALF_CYC = (MBR_SCL_HALF_NS + MBR_SYS_NS - 1) / MBR_SYS_NS;
endpackage

// ### hw/mbr_i2c_if.sv
// Two-wire link between the bus master end and the register slave end.
// Both wires are open drain with an implied pull-up; enables are active low.
`timescale 1ns/1ps
interface mbr_i2c_if;
   logic m_scl_o;
   logic m_scl_oe_b;
   logic m_sda_o;
   logic m_sda_oe_b;
   logic s_sda_o;
   logic s_sda_oe_b;
   logic scl;
   logic sda;

   assign scl = (!m_scl_oe_b && !m_scl_o) ? 1'b0 : 1'b1;
   assign sda = ((!m_sda_oe_b && !m_sda_o) || (!s_sda_oe_b && !s_sda_o)) ? 1'b0 : 1'b1;

   modport master (output m_scl_o, output m_scl_oe_b, output m_sda_o, output m_sda_oe_b,
                   input scl, input sda);
   modport slave (output s_sda_o, output s_sda_oe_b, input scl, input sda);
endinterface

// ### hw/mbr_slave.sv
// Register slave end: answers a multi-byte register read on the two-wire link.
// Assumes SCL comes only from the master end; SCL and SDA are synchronised here.
`timescale 1ns/1ps
module mbr_slave #(
   parameter int NREG = mbr_pkg::MBR_NREG,
   parameter logic [6:0] DEV_ADDR = mbr_pkg::MBR_DEV_ADDR
) (
   input wire logic i_clk_sys,
   input wire logic i_rst_b,
   mbr_i2c_if.slave bus,
   input wire logic i_wr_en,
   input wire logic [7:0] i_wr_idx,
   input wire logic [7:0] i_wr_data,
   output logic [7:0] o_ptr
);
   import mbr_pkg::*;

   typedef enum logic [2:0] {S_IDLE, S_ADDR, S_AACK, S_REG, S_RACK, S_TX, S_MACK} mbr_sst_t;

   typedef struct packed {
      mbr_sst_t st;
      logic [2:0] scl_s;
      logic [2:0] sda_s;
      logic [7:0] sh;
      logic [3:0] cnt;
      logic rw;
      logic [7:0] ptr;
      logic oe_b;
      logic [NREG-1:0][7:0] regs;
   } mbr_sstate_t;

   mbr_sstate_t q;
   mbr_sstate_t d;
   logic scl_rise;
   logic scl_fall;
   logic start_seen;
   logic stop_seen;

   always_comb begin
      d = q;
      d.scl_s = {q.scl_s[1:0], bus.scl};
      d.sda_s = {q.sda_s[1:0], bus.sda};
      scl_rise = q.scl_s[1] && !q.scl_s[2];
      scl_fall = !q.scl_s[1] && q.scl_s[2];
      start_seen = q.scl_s[1] && q.scl_s[2] && !q.sda_s[1] && q.sda_s[2];
      stop_seen = q.scl_s[1] && q.scl_s[2] && q.sda_s[1] && !q.sda_s[2];
      if (i_wr_en && (int'(i_wr_idx) < NREG)) begin
         d.regs[i_wr_idx] = i_wr_data;
      end
      if (start_seen) begin
         // The pointer is left alone so a repeated start reads from the loaded index.
         d.st = S_ADDR;
         d.cnt = 4'h0;
         d.oe_b = 1'b1;
      end else if (stop_seen) begin
         d.st = S_IDLE;
         d.oe_b = 1'b1;
      end else begin
         case (q.st)
            S_IDLE: begin
               d.oe_b = 1'b1;
            end
            S_ADDR, S_REG: begin
               if (scl_rise) begin
                  d.sh = {q.sh[6:0], q.sda_s[1]};
                  d.cnt = q.cnt + 4'h1;
               end else if (scl_fall && q.cnt == MBR_ACK_SLOT) begin
                  if (q.st == S_REG) begin
                     d.ptr = (int'(q.sh) < NREG) ? q.sh : MBR_PTR_RST;
                     d.oe_b = MBR_ACK;
                     d.st = S_RACK;
                  end else if (q.sh[7:1] == DEV_ADDR) begin
                     d.rw = q.sh[0];
                     d.oe_b = MBR_ACK;
                     d.st = S_AACK;
                  end else begin
                     d.st = S_IDLE;
                  end
               end
            end
            S_AACK: begin
               // Also entered after a master acknowledge, to load the next byte on the fall.
               if (scl_fall) begin
                  if (q.rw == MBR_RW_READ) begin
                     d.sh = q.regs[q.ptr];
                     d.oe_b = q.regs[q.ptr][7];
                     d.cnt = 4'h1;
                     d.st = S_TX;
                  end else begin
                     d.oe_b = 1'b1;
                     d.cnt = 4'h0;
                     d.st = S_REG;
                  end
               end
            end
            S_RACK: begin
               if (scl_fall) begin
                  d.oe_b = 1'b1;
                  d.st = S_IDLE;
               end
            end
            S_TX: begin
               if (scl_fall) begin
                  if (q.cnt == MBR_ACK_SLOT) begin
                     d.oe_b = 1'b1;
                     d.st = S_MACK;
                     // Advance after the byte, wrapping past the top register.
                     d.ptr = (int'(q.ptr) >= NREG - 1) ? MBR_PTR_RST : q.ptr + 8'h01;
                  end else begin
                     d.oe_b = q.sh[6];
                     d.sh = {q.sh[6:0], 1'b0};
                     d.cnt = q.cnt + 4'h1;
                  end
               end
            end
            S_MACK: begin
               if (scl_rise) begin
                  if (q.sda_s[1] == MBR_ACK) begin
                     d.st = S_AACK;
                  end else begin
                     d.st = S_IDLE;
                  end
               end
            end
            default: begin
               d.st = S_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         q <= '{st: S_IDLE, scl_s: 3'h7, sda_s: 3'h7, sh: 8'h00, cnt: 4'h0, rw: 1'b0,
                ptr: MBR_PTR_RST, oe_b: 1'b1, regs: {NREG{MBR_REG_RST}}};
      end else begin
         q <= d;
      end
   end

   // Open drain: only a low is ever driven.
   assign bus.s_sda_o = 1'b0;
   assign bus.s_sda_oe_b = q.oe_b;
   assign o_ptr = q.ptr;
endmodule

// ### hw/mbr_master.sv
// Bus master end: runs a multi-byte register read and hands the bytes to a user through
// a two-entry buffer. Assumes the far end never stretches SCL; SDA is synchronised here.
`timescale 1ns/1ps
module mbr_master #(
   parameter logic [6:0] DEV_ADDR = mbr_pkg::MBR_DEV_ADDR,
   parameter int HALF_CYC = mbr_pkg::MBR_SCL_HALF_CYC
) (
   input wire logic i_clk_sys,
   input wire logic i_rst_b,
   mbr_i2c_if.master bus,
   input wire logic i_go,
   input wire logic [7:0] i_start_idx,
   input wire logic [7:0] i_count,
   output logic o_busy,
   output logic o_addr_nack,
   output logic o_valid,
   output logic [7:0] o_data,
   input wire logic i_ready
);
   import mbr_pkg::*;

   localparam int DIVW = $clog2(HALF_CYC + 1);

   typedef enum logic [3:0] {
      M_IDLE, M_STA_A, M_STA_B, M_BIT_LO, M_BIT_SET, M_BIT_HI, M_RS_A, M_RS_B,
      M_STO_A, M_STO_B, M_STO_C
   } mbr_mst_t;

   typedef enum logic [1:0] {PH_ADDR_W, PH_REG, PH_ADDR_R, PH_DATA} mbr_ph_t;

   typedef struct packed {
      mbr_mst_t st;
      mbr_ph_t ph;
      logic [DIVW-1:0] div;
      logic [1:0] sda_s;
      logic [7:0] sh;
      logic [3:0] cnt;
      logic [7:0] left;
      logic [7:0] idx;
      logic scl_oe_b;
      logic sda_oe_b;
      logic busy;
      logic nack;
      logic out_v;
      logic [7:0] out_d;
      logic sk_v;
      logic [7:0] sk_d;
   } mbr_mstate_t;

   mbr_mstate_t q;
   mbr_mstate_t d;
   logic tick;
   logic push;
   logic sda_in;

   always_comb begin
      d = q;
      push = 1'b0;
      d.sda_s = {q.sda_s[0], bus.sda};
      sda_in = q.sda_s[1];
      tick = (q.div == DIVW'(HALF_CYC - 1));
      if (q.st != M_IDLE) begin
         d.div = tick ? '0 : q.div + DIVW'(1);
      end
      case (q.st)
         M_IDLE: begin
            d.div = '0;
            if (i_go) begin
               d.busy = 1'b1;
               d.nack = 1'b0;
               d.ph = PH_ADDR_W;
               d.sh = {DEV_ADDR, MBR_RW_WRITE};
               d.left = (i_count == 8'h00) ? 8'h01 : i_count;
               d.idx = i_start_idx;
               d.st = M_STA_A;
            end
         end
         M_STA_A: begin
            if (tick) begin
               d.sda_oe_b = 1'b0;
               d.st = M_STA_B;
            end
         end
         M_STA_B: begin
            if (tick) begin
               d.scl_oe_b = 1'b0;
               d.cnt = 4'h0;
               d.st = M_BIT_LO;
            end
         end
         M_BIT_LO: begin
            if (tick) begin
               if (q.cnt != MBR_ACK_SLOT) begin
                  d.sda_oe_b = (q.ph == PH_DATA) ? 1'b1 : q.sh[7];
                  d.st = M_BIT_SET;
               end else if (q.ph != PH_DATA) begin
                  d.sda_oe_b = 1'b1;
                  d.st = M_BIT_SET;
               end else if (!q.sk_v) begin
                  push = 1'b1;
                  d.sda_oe_b = (q.left == 8'h01) ? MBR_NACK : MBR_ACK;
                  d.st = M_BIT_SET;
               end else begin
                  // A full buffer holds SCL low here, so the slave waits and no byte is lost.
                  d.div = q.div;
               end
            end
         end
         M_BIT_SET: begin
            if (tick) begin
               d.scl_oe_b = 1'b1;
               d.st = M_BIT_HI;
            end
         end
         M_BIT_HI: begin
            if (tick) begin
               d.scl_oe_b = 1'b0;
               if (q.cnt != MBR_ACK_SLOT) begin
                  d.sh = {q.sh[6:0], sda_in};
                  d.cnt = q.cnt + 4'h1;
                  d.st = M_BIT_LO;
                  // Let go as SCL falls into the slave's acknowledge slot.
                  // The slave pulls low a few clocks later, so the two drivers never overlap.
                  if (q.cnt == MBR_ACK_SLOT - 4'h1) begin
                     d.sda_oe_b = 1'b1;
                  end
               end else begin
                  d.cnt = 4'h0;
                  case (q.ph)
                     PH_ADDR_W: begin
                        if (sda_in == MBR_ACK) begin
                           d.ph = PH_REG;
                           d.sh = q.idx;
                           d.st = M_BIT_LO;
                        end else begin
                           d.nack = 1'b1;
                           d.st = M_STO_A;
                        end
                     end
                     PH_REG: begin
                        if (sda_in == MBR_ACK) begin
                           d.st = M_RS_A;
                        end else begin
                           d.nack = 1'b1;
                           d.st = M_STO_A;
                        end
                     end
                     PH_ADDR_R: begin
                        if (sda_in == MBR_ACK) begin
                           d.ph = PH_DATA;
                           d.st = M_BIT_LO;
                        end else begin
                           d.nack = 1'b1;
                           d.st = M_STO_A;
                        end
                     end
                     default: begin
                        if (q.left == 8'h01) begin
                           d.st = M_STO_A;
                        end else begin
                           d.left = q.left - 8'h01;
                           // Drop the acknowledge as SCL falls, before the slave drives its next bit.
                           d.sda_oe_b = 1'b1;
                           d.st = M_BIT_LO;
                        end
                     end
                  endcase
               end
            end
         end
         M_RS_A: begin
            if (tick) begin
               d.sda_oe_b = 1'b1;
               d.st = M_RS_B;
            end
         end
         M_RS_B: begin
            if (tick) begin
               d.scl_oe_b = 1'b1;
               d.ph = PH_ADDR_R;
               d.sh = {DEV_ADDR, MBR_RW_READ};
               d.st = M_STA_A;
            end
         end
         M_STO_A: begin
            if (tick) begin
               d.sda_oe_b = 1'b0;
               d.st = M_STO_B;
            end
         end
         M_STO_B: begin
            if (tick) begin
               d.scl_oe_b = 1'b1;
               d.st = M_STO_C;
            end
         end
         M_STO_C: begin
            if (tick) begin
               d.sda_oe_b = 1'b1;
               d.busy = 1'b0;
               d.st = M_IDLE;
            end
         end
         default: begin
            d.st = M_IDLE;
         end
      endcase
      // Two-entry skid buffer: output stage plus one spare that accepts while stalled.
      if (q.out_v && i_ready) begin
         d.out_v = q.sk_v;
         d.out_d = q.sk_d;
         d.sk_v = 1'b0;
      end
      if (push) begin
         if (!d.out_v) begin
            d.out_v = 1'b1;
            d.out_d = q.sh;
         end else begin
            d.sk_v = 1'b1;
            d.sk_d = q.sh;
         end
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         q <= '{st: M_IDLE, ph: PH_ADDR_W, div: '0, sda_s: 2'h3, sh: 8'h00, cnt: 4'h0,
                left: 8'h00, idx: 8'h00, scl_oe_b: 1'b1, sda_oe_b: 1'b1, busy: 1'b0,
                nack: 1'b0, out_v: 1'b0, out_d: 8'h00, sk_v: 1'b0, sk_d: 8'h00};
      end else begin
         q <= d;
      end
   end

   assign bus.m_scl_o = 1'b0;
   assign bus.m_sda_o = 1'b0;
   assign bus.m_scl_oe_b = q.scl_oe_b;
   assign bus.m_sda_oe_b = q.sda_oe_b;
   assign o_busy = q.busy;
   assign o_addr_nack = q.nack;
   assign o_valid = q.out_v;
   assign o_data = q.out_d;
endmodule

// ### bench/mbr_link_checker.sv
// Concurrent checks on the two-wire link between the master end and the slave end.
// Assumes its inputs are the link's enables and resolved wires, in the system clock domain.
`timescale 1ns/1ps
module mbr_link_checker (
   input wire logic i_clk_sys,
   input wire logic i_rst_b,
   input wire logic m_scl_oe_b,
   input wire logic m_sda_oe_b,
   input wire logic s_sda_oe_b,
   input wire logic scl,
   input wire logic sda
);
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (!i_rst_b);

   property p_slave_change_low;
      $changed(s_sda_oe_b) |-> !scl && $past(!scl);
   endproperty
   a_slave_change_low: assert property (p_slave_change_low)
      else $error("slave data changed while the clock was high");

   property p_no_contention;
      !(!s_sda_oe_b && !m_sda_oe_b);
   endproperty
   a_no_contention: assert property (p_no_contention)
      else $error("both ends pull the data line together");

   property p_start_released;
      ($fell(sda) && scl) |-> s_sda_oe_b;
   endproperty
   a_start_released: assert property (p_start_released)
      else $error("slave holds the data line at a start");

   property p_stop_released;
      ($rose(sda) && scl) |-> s_sda_oe_b && $past(s_sda_oe_b);
   endproperty
   a_stop_released: assert property (p_stop_released)
      else $error("slave holds the data line at a stop");

   property p_scl_high_hold;
      $rose(scl) |-> scl[*4];
   endproperty
   a_scl_high_hold: assert property (p_scl_high_hold)
      else $error("clock high phase too short");

   property p_scl_low_hold;
      $fell(scl) |-> (!scl)[*4];
   endproperty
   a_scl_low_hold: assert property (p_scl_low_hold)
      else $error("clock low phase too short");

   property p_slave_hold_high;
      (!s_sda_oe_b && $rose(scl)) |-> (!s_sda_oe_b)[*4];
   endproperty
   a_slave_hold_high: assert property (p_slave_hold_high)
      else $error("slave bit not held through the clock high phase");

   property p_idle_released;
      scl[*8] |-> s_sda_oe_b;
   endproperty
   a_idle_released: assert property (p_idle_released)
      else $error("slave drives the data line while the clock idles high");
endmodule

// ### bench/i2c_multi_byte_register_read_tb.sv
// Bench: master and slave ends on one link, compared with a register model at every byte.
// Assumes the package, interface and both ends compile first; the master makes the link clock.
`timescale 1ns/1ps
module i2c_multi_byte_register_read_tb;
   import mbr_pkg::*;
   // A short half period keeps the run small; the slave needs at least four clocks.
   localparam int HALF = 6;
   logic i_clk_sys, i_rst_b, i_go, i_ready, i_wr_en, o_busy, o_addr_nack, o_valid;
   logic [7:0] i_start_idx, i_count, i_wr_idx, i_wr_data, o_data, o_ptr, sh;
   logic [7:0] addr_seen[2];
   logic ack_seen[2];
   logic last_ack, scl_p, sda_p, first;
   int mismatches, num_checks, cycles, starts, stops, bitn;
   int mdl[MBR_NREG];

   mbr_i2c_if bus_if();
   mbr_master #(.HALF_CYC(HALF)) mbr_master_inst (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b),
      .bus(bus_if.master), .i_go(i_go), .i_start_idx(i_start_idx), .i_count(i_count),
      .o_busy(o_busy), .o_addr_nack(o_addr_nack), .o_valid(o_valid), .o_data(o_data),
      .i_ready(i_ready));
   mbr_slave mbr_slave_inst (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .bus(bus_if.slave),
      .i_wr_en(i_wr_en), .i_wr_idx(i_wr_idx), .i_wr_data(i_wr_data), .o_ptr(o_ptr));
   mbr_link_checker mbr_link_checker_inst (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b),
      .m_scl_oe_b(bus_if.m_scl_oe_b), .m_sda_oe_b(bus_if.m_sda_oe_b),
      .s_sda_oe_b(bus_if.s_sda_oe_b), .scl(bus_if.scl), .sda(bus_if.sda));

   initial begin
      i_clk_sys = 0;
      forever #20 i_clk_sys = ~i_clk_sys;
   end

   task automatic results();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
      num_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   // Link monitor: counts starts and stops, captures the address byte after each of the first two starts.
   always @(posedge i_clk_sys) begin
      cycles++;
      if (scl_p && bus_if.scl && sda_p && !bus_if.sda) begin
         starts++;
         bitn = 0;
         first = 1;
      end
      if (scl_p && bus_if.scl && !sda_p && bus_if.sda) stops++;
      if (!scl_p && bus_if.scl) begin
         bitn++;
         if (bitn <= 8) sh = {sh[6:0], bus_if.sda};
         else begin
            last_ack = bus_if.sda;
            if (first && starts > 0 && starts <= 2) begin
               addr_seen[starts-1] = sh;
               ack_seen[starts-1] = bus_if.sda;
            end
            first = 0;
            bitn = 0;
         end
      end
      scl_p = bus_if.scl;
      sda_p = bus_if.sda;
      if (cycles > 60000) begin
         mismatches++;
         results();
      end
   end

   task automatic wr(input logic [7:0] idx, input logic [7:0] dat);
      @(posedge i_clk_sys);
      i_wr_en <= 1;
      i_wr_idx <= idx;
      i_wr_data <= dat;
      @(posedge i_clk_sys);
      i_wr_en <= 0;
      if (idx < MBR_NREG) mdl[idx] = dat;
   endtask

   task automatic rd(input logic [7:0] k, input logic [7:0] c);
      int n, got, ptr, w;
      n = (c == 0) ? 1 : c;
      ptr = (k < MBR_NREG) ? k : 0;
      got = 0;
      w = 0;
      starts = 0;
      stops = 0;
      // Clear what the monitor captured last time, so a silent link cannot pass.
      addr_seen = '{8'h00, 8'h00};
      ack_seen = '{MBR_NACK, MBR_NACK};
      last_ack = MBR_ACK;
      @(posedge i_clk_sys);
      i_go <= 1;
      i_start_idx <= k;
      i_count <= c;
      @(posedge i_clk_sys);
      i_go <= 0;
      @(posedge i_clk_sys);
      while ((o_busy === 1'b1 || o_valid === 1'b1) && w < 20000) begin
         if (o_valid === 1'b1 && i_ready === 1'b1) begin
            chk(o_data, 8'(mdl[ptr]), "read data");
            ptr = (ptr + 1) % MBR_NREG;
            got++;
         end
         // Long stalls fill both buffer entries and freeze the link for a while.
         if (w % 700 < 400) i_ready <= 0;
         else i_ready <= 1'($urandom % 2);
         @(posedge i_clk_sys);
         w++;
      end
      repeat (2) @(posedge i_clk_sys);
      chk(8'(got), 8'(n), "byte count");
      chk(8'(starts), 8'h02, "start count");
      chk(8'(stops), 8'h01, "stop count");
      chk(addr_seen[0], {MBR_DEV_ADDR, MBR_RW_WRITE}, "write address");
      chk(addr_seen[1], {MBR_DEV_ADDR, MBR_RW_READ}, "read address");
      chk({7'h00, ack_seen[0]}, {7'h00, MBR_ACK}, "write address ack");
      chk({7'h00, ack_seen[1]}, {7'h00, MBR_ACK}, "read address ack");
      chk({7'h00, last_ack}, {7'h00, MBR_NACK}, "final ack bit");
      chk({7'h00, o_addr_nack}, 8'h00, "address refused");
      chk(o_ptr, 8'(ptr), "pointer after read");
   endtask

   initial begin
      i_rst_b = 0;
      i_go = 0;
      i_ready = 0;
      i_wr_en = 0;
      i_start_idx = 8'h00;
      i_count = 8'h00;
      i_wr_idx = 8'h00;
      i_wr_data = 8'h00;
      mismatches = 0;
      num_checks = 0;
      cycles = 0;
      starts = 0;
      stops = 0;
      bitn = 0;
      scl_p = 1;
      sda_p = 1;
      first = 0;
      void'($urandom(34));
      repeat (10) @(posedge i_clk_sys);
      i_rst_b <= 1;
      @(posedge i_clk_sys);
      chk(o_ptr, MBR_PTR_RST, "pointer at reset");
      chk({7'h00, o_valid}, 8'h00, "valid at reset");
      for (int i = 0; i < MBR_NREG; i++) wr(8'(i), 8'($urandom));
      wr(8'h10, 8'h5a);
      rd(8'h03, 8'h04);
      rd(8'h0e, 8'h05);
      rd(8'h0f, 8'h01);
      rd(8'h00, 8'h00);
      rd(8'hc8, 8'h03);
      rd(8'h09, 8'h12);
      for (int t = 0; t < 3; t++) rd(8'($urandom % 16), 8'(1 + $urandom % 6));
      results();
   end
endmodule
